// file: hw/prg_gateway.sv
// Parameter record gateway: turns CIP explicit requests on the parameter object
// into record fetch/store accesses and returns CIP status and data.
// Assumes the client side and the record side both use valid/ready handshakes.
// Behaviour
// - Requests go to class 0x66; instance 0..255 selects the record.
// - Fetch response gives length in bytes 0..3, record bytes from byte 4.
// - Successful store answers with status only, no payload bytes.
// - Too few request bytes answered with status 0x06, unless a foreign class (0x05) or unsupported service (0x08) is refused first.
// - Firmware activation suspends cyclic data on both sides until it completes.
// - Writable objects return to factory defaults on a new unit.
`timescale 1ns/1ps
module prg_gateway (
  input wire logic clk, // 100 MHz clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic hdrValid, // Request header offered.
  output logic hdrReady, // Header taken.
  input wire logic [7:0] hdrService, // CIP service code.
  input wire logic [7:0] hdrClass, // CIP class code.
  input wire logic [7:0] hdrInstance, // Instance, used as record index.
  input wire logic hdrEmpty, // Request has no payload bytes.
  input wire logic reqValid, // Request byte offered.
  output logic reqReady, // Request byte taken.
  input wire logic [7:0] reqData, // Request byte.
  input wire logic reqLast, // Final request byte.
  output logic rspByteValid, // Response data byte valid.
  input wire logic rspByteReady, // Client takes response byte.
  output logic [7:0] rspByte, // Response data byte.
  output logic rspValid, // Response status valid, ends a transaction.
  input wire logic rspReady, // Client takes status.
  output logic [7:0] rspStatus, // CIP general status.
  output logic recReqValid, // Record access request.
  input wire logic recReqReady, // Record side takes request.
  output logic recReqStore, // 1 store service, 0 fetch service.
  output logic [7:0] recIndex, // Record index.
  output logic [31:0] recLength, // Fetched or stored byte count.
  output logic recAbort, // Pulse: cancel an incomplete store.
  output logic recWrValid, // Store byte valid.
  input wire logic recWrReady, // Record side takes store byte.
  output logic [7:0] recWrData, // Store byte.
  input wire logic recRspValid, // Record reply valid.
  output logic recRspReady, // Reply taken.
  input wire logic [7:0] fieldbusErrorClassCode, // Record reply error code.
  input wire logic [31:0] recRspLength, // Fetched byte count in reply.
  input wire logic recRdValid, // Fetched byte valid.
  output logic recRdReady, // Fetched byte taken.
  input wire logic [7:0] recRdData, // Fetched byte.
  input wire logic fwActivateStart, // Pulse: firmware activation begins.
  input wire logic fwActivateDone, // Pulse: firmware activation finished.
  input wire logic factoryRestore, // Pulse: restore factory settings.
  output logic cyclicHoldNetA, // Suspend cyclic data, network side A.
  output logic cyclicHoldNetB, // Suspend cyclic data, network side B.
  output logic loadDefaults // Pulse: writable objects to factory values.
);

  prg_pkg::prg_state_e state_ff, nxt_state;
  logic [31:0] len_ff, nxt_len;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [2:0] idx_ff, nxt_idx;
  logic store_ff, nxt_store;
  logic [7:0] index_ff, nxt_index;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] wrByte_ff, nxt_wrByte;
  logic wrValid_ff, nxt_wrValid;
  logic [7:0] outByte_ff, nxt_outByte;
  logic outValid_ff, nxt_outValid;
  logic abort_ff, nxt_abort;
  logic hold_ff, nxt_hold;
  logic dflt_ff, nxt_dflt;
  logic [7:0] xlated;
  logic lenAccept;
  logic wrAccept;
  logic wrSlot;
  logic outSlot;

  prg_status_xlate u_xlate (
    .errCode(fieldbusErrorClassCode),
    .cipStatus(xlated)
  );

  assign hdrReady = (state_ff == prg_pkg::ST_IDLE);
  assign wrSlot = !wrValid_ff || recWrReady;
  assign outSlot = !outValid_ff || rspByteReady;
  assign lenAccept = (state_ff == prg_pkg::ST_LEN) && reqValid;
  assign wrAccept = (state_ff == prg_pkg::ST_WDATA) && reqValid && wrSlot && cnt_ff != 32'h0;
  assign reqReady = lenAccept || wrAccept || (state_ff == prg_pkg::ST_DRAIN);
  assign recRspReady = (state_ff == prg_pkg::ST_WAIT);
  assign recRdReady = (state_ff == prg_pkg::ST_RDATA) && idx_ff == prg_pkg::LEN_BYTES
                      && cnt_ff != 32'h0 && outSlot;
  assign recReqValid = (state_ff == prg_pkg::ST_ISSUE);
  assign recReqStore = store_ff;
  assign recIndex = index_ff;
  assign recLength = len_ff;
  assign recAbort = abort_ff;
  assign recWrValid = wrValid_ff;
  assign recWrData = wrByte_ff;
  assign rspByteValid = outValid_ff;
  assign rspByte = outByte_ff;
  assign rspValid = (state_ff == prg_pkg::ST_RESP);
  assign rspStatus = status_ff;
  assign cyclicHoldNetA = hold_ff;
  assign cyclicHoldNetB = hold_ff;
  assign loadDefaults = dflt_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_len = len_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_store = store_ff;
    nxt_index = index_ff;
    nxt_status = status_ff;
    nxt_wrByte = wrByte_ff;
    nxt_wrValid = wrValid_ff && !recWrReady;
    nxt_outByte = outByte_ff;
    nxt_outValid = outValid_ff && !rspByteReady;
    nxt_abort = 1'b0;
    case (state_ff)
      prg_pkg::ST_IDLE: begin
        if (hdrValid) begin
          nxt_store = (hdrService == prg_pkg::SVC_STORE);
          nxt_index = hdrInstance;
          nxt_len = 32'h0;
          nxt_idx = 3'h0;
          if (hdrClass != prg_pkg::CLASS_PARAM) begin
            nxt_status = prg_pkg::CIP_PATH_UNKNOWN;
            nxt_state = hdrEmpty ? prg_pkg::ST_RESP : prg_pkg::ST_DRAIN;
          end else if (hdrService != prg_pkg::SVC_FETCH
                       && hdrService != prg_pkg::SVC_STORE) begin
            nxt_status = prg_pkg::CIP_SVC_UNSUPPORTED;
            nxt_state = hdrEmpty ? prg_pkg::ST_RESP : prg_pkg::ST_DRAIN;
          end else if (hdrEmpty) begin
            nxt_status = prg_pkg::CIP_PARTIAL;
            nxt_state = prg_pkg::ST_RESP;
          end else begin
            nxt_state = prg_pkg::ST_LEN;
          end
        end
      end
      prg_pkg::ST_LEN: begin
        if (reqValid) begin
          nxt_len = prg_pkg::shiftLen(len_ff, reqData);
          nxt_idx = idx_ff + 3'h1;
          nxt_cnt = nxt_len;
          if (idx_ff != prg_pkg::LEN_LAST_IDX) begin
            if (reqLast) begin
              nxt_status = prg_pkg::CIP_PARTIAL;
              nxt_state = prg_pkg::ST_RESP;
            end
          end else if (store_ff && reqLast && nxt_len != 32'h0) begin
            nxt_status = prg_pkg::CIP_PARTIAL;
            nxt_state = prg_pkg::ST_RESP;
          end else if (!reqLast && !(store_ff && nxt_len != 32'h0)) begin
            nxt_status = prg_pkg::CIP_TOO_MUCH;
            nxt_state = prg_pkg::ST_DRAIN;
          end else begin
            nxt_state = prg_pkg::ST_ISSUE;
          end
        end
      end
      prg_pkg::ST_ISSUE: begin
        if (recReqReady) begin
          nxt_state = (store_ff && len_ff != 32'h0) ? prg_pkg::ST_WDATA : prg_pkg::ST_WAIT;
        end
      end
      prg_pkg::ST_WDATA: begin
        if (wrAccept) begin
          nxt_wrByte = reqData;
          nxt_wrValid = 1'b1;
          nxt_cnt = cnt_ff - 32'h1;
          if (cnt_ff == 32'h1 && !reqLast) begin
            nxt_abort = 1'b1;
            nxt_wrValid = 1'b0;
            nxt_status = prg_pkg::CIP_TOO_MUCH;
            nxt_state = prg_pkg::ST_DRAIN;
          end else if (cnt_ff != 32'h1 && reqLast) begin
            // The record side already took the store access and any earlier bytes, so it is cancelled.
            nxt_abort = 1'b1;
            nxt_wrValid = 1'b0;
            nxt_status = prg_pkg::CIP_PARTIAL;
            nxt_state = prg_pkg::ST_RESP;
          end
        end else if (cnt_ff == 32'h0 && !wrValid_ff) begin
          nxt_state = prg_pkg::ST_WAIT;
        end
      end
      prg_pkg::ST_WAIT: begin
        if (recRspValid) begin
          nxt_status = xlated;
          nxt_idx = 3'h0;
          if (fieldbusErrorClassCode == prg_pkg::REC_OK && !store_ff) begin
            nxt_len = recRspLength;
            nxt_cnt = recRspLength;
            nxt_state = prg_pkg::ST_RDATA;
          end else begin
            nxt_state = prg_pkg::ST_RESP;
          end
        end
      end
      prg_pkg::ST_RDATA: begin
        if (outSlot && idx_ff != prg_pkg::LEN_BYTES) begin
          nxt_outByte = len_ff[31:24];
          nxt_len = {len_ff[23:0], 8'h0};
          nxt_outValid = 1'b1;
          nxt_idx = idx_ff + 3'h1;
        end else if (recRdReady && recRdValid) begin
          nxt_outByte = recRdData;
          nxt_outValid = 1'b1;
          nxt_cnt = cnt_ff - 32'h1;
        end else if (idx_ff == prg_pkg::LEN_BYTES && cnt_ff == 32'h0 && !outValid_ff) begin
          nxt_state = prg_pkg::ST_RESP;
        end
      end
      prg_pkg::ST_DRAIN: begin
        if (reqValid && reqLast) begin
          nxt_state = prg_pkg::ST_RESP;
        end
      end
      prg_pkg::ST_RESP: begin
        if (rspReady) begin
          nxt_state = prg_pkg::ST_IDLE;
        end
      end
      default: nxt_state = prg_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    // A start arriving with a done keeps the hold, so no activation is missed.
    nxt_hold = fwActivateStart || (hold_ff && !fwActivateDone);
    nxt_dflt = factoryRestore;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= prg_pkg::ST_IDLE;
      len_ff <= 32'h0;
      cnt_ff <= 32'h0;
      idx_ff <= 3'h0;
      store_ff <= 1'b0;
      index_ff <= 8'h0;
      status_ff <= 8'h0;
      wrByte_ff <= 8'h0;
      wrValid_ff <= 1'b0;
      outByte_ff <= 8'h0;
      outValid_ff <= 1'b0;
      abort_ff <= 1'b0;
      hold_ff <= 1'b0;
      // A fresh unit comes out of reset loading factory values.
      dflt_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      len_ff <= nxt_len;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      store_ff <= nxt_store;
      index_ff <= nxt_index;
      status_ff <= nxt_status;
      wrByte_ff <= nxt_wrByte;
      wrValid_ff <= nxt_wrValid;
      outByte_ff <= nxt_outByte;
      outValid_ff <= nxt_outValid;
      abort_ff <= nxt_abort;
      hold_ff <= nxt_hold;
      dflt_ff <= nxt_dflt;
    end
  end

endmodule

// file: hw/prg_pkg.sv
// Constants shared by the parameter record gateway and its status translator.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package prg_pkg;

  localparam logic [7:0] CLASS_PARAM = 8'h66;
  localparam int INSTANCE_COUNT = 256;
  localparam logic [7:0] SVC_FETCH = 8'h32;
  localparam logic [7:0] SVC_STORE = 8'h33;
  localparam logic [2:0] LEN_BYTES = 3'h4;
  localparam logic [2:0] LEN_LAST_IDX = 3'h3;

  // CIP general status codes.
  localparam logic [7:0] CIP_SUCCESS = 8'h00;
  localparam logic [7:0] CIP_RESOURCE_UNAVAIL = 8'h02;
  localparam logic [7:0] CIP_INVALID_PARAM_VAL = 8'h03;
  localparam logic [7:0] CIP_PATH_UNKNOWN = 8'h05;
  localparam logic [7:0] CIP_PARTIAL = 8'h06;
  localparam logic [7:0] CIP_SVC_UNSUPPORTED = 8'h08;
  localparam logic [7:0] CIP_INVALID_ATTR_VAL = 8'h09;
  localparam logic [7:0] CIP_OBJ_STATE = 8'h0c;
  localparam logic [7:0] CIP_NOT_SETTABLE = 8'h0e;
  localparam logic [7:0] CIP_PRIVILEGE = 8'h0f;
  localparam logic [7:0] CIP_DEV_STATE = 8'h10;
  localparam logic [7:0] CIP_ATTR_UNSUPPORTED = 8'h14;
  localparam logic [7:0] CIP_TOO_MUCH = 8'h15;
  localparam logic [7:0] CIP_NO_OBJECT = 8'h16;
  localparam logic [7:0] CIP_EMBEDDED = 8'h1e;
  localparam logic [7:0] CIP_VENDOR = 8'h1f;
  localparam logic [7:0] CIP_INVALID_PARAM = 8'h20;
  localparam logic [7:0] CIP_MSG_FORMAT = 8'h24;
  localparam logic [7:0] CIP_MEMBER_NOT_SET = 8'h29;
  localparam logic [7:0] CIP_NOT_GETTABLE = 8'h2c;

  // Record-side error class codes.
  localparam logic [7:0] REC_OK = 8'h00;
  localparam logic [7:0] REC_BUSY = 8'ha7;
  localparam logic [7:0] REC_NOT_SUPPORTED = 8'ha9;
  localparam logic [7:0] REC_BAD_INDEX = 8'hb0;
  localparam logic [7:0] REC_WRITE_LEN = 8'hb1;
  localparam logic [7:0] REC_BAD_SLOT = 8'hb2;
  localparam logic [7:0] REC_TYPE_CONFLICT = 8'hb3;
  localparam logic [7:0] REC_BAD_AREA = 8'hb4;
  localparam logic [7:0] REC_STATE_CONFLICT = 8'hb5;
  localparam logic [7:0] REC_ACCESS_DENIED = 8'hb6;
  localparam logic [7:0] REC_BAD_RANGE = 8'hb7;
  localparam logic [7:0] REC_BAD_PARAM = 8'hb8;
  localparam logic [7:0] REC_BAD_TYPE = 8'hb9;
  localparam logic [7:0] REC_READ_CONSTRAIN = 8'hc0;
  localparam logic [7:0] REC_WRITE_CONSTRAIN = 8'hc1;
  localparam logic [7:0] REC_RES_BUSY = 8'hc2;
  localparam logic [7:0] REC_RES_UNAVAIL = 8'hc3;
  localparam logic [7:0] REC_BAD_STRUCT = 8'he0;
  localparam logic [7:0] REC_BAD_USER_PARAM = 8'he1;

  typedef enum {
    ST_IDLE, ST_LEN, ST_ISSUE, ST_WDATA, ST_WAIT, ST_RDATA, ST_DRAIN, ST_RESP
  } prg_state_e;

  // Shifts one byte into a big-endian length accumulator.
  function automatic logic [31:0] shiftLen(input logic [31:0] acc, input logic [7:0] b);
    return {acc[23:0], b};
  endfunction

endpackage

// file: hw/prg_status_xlate.sv
// Translation of record-side error class codes into CIP general status.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module prg_status_xlate (
  input wire logic [7:0] errCode, // Record-side error class code.
  output logic [7:0] cipStatus // Matching CIP general status.
);

  always_comb begin
    case (errCode)
      prg_pkg::REC_OK: cipStatus = prg_pkg::CIP_SUCCESS;
      prg_pkg::REC_BUSY: cipStatus = prg_pkg::CIP_EMBEDDED;
      prg_pkg::REC_NOT_SUPPORTED: cipStatus = prg_pkg::CIP_ATTR_UNSUPPORTED;
      prg_pkg::REC_BAD_INDEX: cipStatus = prg_pkg::CIP_INVALID_ATTR_VAL;
      prg_pkg::REC_WRITE_LEN: cipStatus = prg_pkg::CIP_TOO_MUCH;
      prg_pkg::REC_BAD_SLOT: cipStatus = prg_pkg::CIP_PATH_UNKNOWN;
      prg_pkg::REC_TYPE_CONFLICT: cipStatus = prg_pkg::CIP_NOT_SETTABLE;
      prg_pkg::REC_BAD_AREA: cipStatus = prg_pkg::CIP_NO_OBJECT;
      prg_pkg::REC_STATE_CONFLICT: cipStatus = prg_pkg::CIP_DEV_STATE;
      prg_pkg::REC_ACCESS_DENIED: cipStatus = prg_pkg::CIP_PRIVILEGE;
      prg_pkg::REC_BAD_RANGE: cipStatus = prg_pkg::CIP_INVALID_PARAM;
      prg_pkg::REC_BAD_PARAM: cipStatus = prg_pkg::CIP_INVALID_PARAM;
      prg_pkg::REC_BAD_TYPE: cipStatus = prg_pkg::CIP_MEMBER_NOT_SET;
      prg_pkg::REC_READ_CONSTRAIN: cipStatus = prg_pkg::CIP_NOT_GETTABLE;
      prg_pkg::REC_WRITE_CONSTRAIN: cipStatus = prg_pkg::CIP_NOT_SETTABLE;
      prg_pkg::REC_RES_BUSY: cipStatus = prg_pkg::CIP_OBJ_STATE;
      prg_pkg::REC_RES_UNAVAIL: cipStatus = prg_pkg::CIP_RESOURCE_UNAVAIL;
      prg_pkg::REC_BAD_STRUCT: cipStatus = prg_pkg::CIP_MSG_FORMAT;
      prg_pkg::REC_BAD_USER_PARAM: cipStatus = prg_pkg::CIP_INVALID_PARAM_VAL;
      default: cipStatus = prg_pkg::CIP_VENDOR;
    endcase
  end

endmodule

// file: bench/prg_gateway_monitor.sv
// Port checker for the parameter record gateway.
// Bound to every prg_gateway; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module prg_gateway_monitor (
  input wire logic clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic hdrValid, // Header offered.
  input wire logic hdrReady, // Header taken.
  input wire logic [7:0] hdrService, // Service code.
  input wire logic [7:0] hdrClass, // Class code.
  input wire logic hdrEmpty, // No payload.
  input wire logic rspByteValid, // Response byte.
  input wire logic rspByteReady, // Client takes byte.
  input wire logic [7:0] rspByte, // Byte value.
  input wire logic rspValid, // Status valid.
  input wire logic rspReady, // Client takes status.
  input wire logic [7:0] rspStatus, // Status.
  input wire logic recReqStore, // Store access.
  input wire logic recRspValid, // Record reply.
  input wire logic recRspReady, // Reply taken.
  input wire logic [7:0] fieldbusErrorClassCode, // Reply code.
  input wire logic fwActivateStart, // Activation begins.
  input wire logic fwActivateDone, // Activation ends.
  input wire logic factoryRestore, // Restore request.
  input wire logic cyclicHoldNetA, // Hold side A.
  input wire logic cyclicHoldNetB, // Hold side B.
  input wire logic loadDefaults // Defaults pulse.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // The status trails its cause by a short internal pipeline, so allow a few cycles.
  sequence s_status(logic [7:0] code);
    ##[1:6] (rspValid && rspStatus == code);
  endsequence
  sequence s_reply(logic [7:0] code);
    recRspValid && recRspReady && fieldbusErrorClassCode == code;
  endsequence
  a_hold_set: assert property (fwActivateStart |=> cyclicHoldNetA && cyclicHoldNetB)
    else $error("cyclic hold not raised");
  a_hold_clear: assert property (
    fwActivateDone && !fwActivateStart |=> !cyclicHoldNetA && !cyclicHoldNetB)
    else $error("cyclic hold not released");
  a_defaults_restore: assert property (factoryRestore |-> ##[1:2] loadDefaults)
    else $error("no defaults pulse");
  a_defaults_pulse: assert property (loadDefaults |=> !loadDefaults)
    else $error("defaults pulse too long");
  a_store_no_bytes: assert property (rspByteValid |-> !recReqStore)
    else $error("store answered with data");
  a_xlate_struct: assert property (s_reply(8'he0) |-> s_status(8'h24))
    else $error("bad structure code not mapped");
  a_xlate_user: assert property (s_reply(8'he1) |-> s_status(8'h03))
    else $error("bad user parameter code not mapped");
  a_xlate_vendor: assert property (
    recRspValid && recRspReady && fieldbusErrorClassCode inside {8'ha0, 8'ha1, 8'ha2, 8'ha8}
    |-> s_status(8'h1f)) else $error("unlisted code not vendor status");
  a_short_header: assert property (
    hdrValid && hdrReady && hdrEmpty && hdrClass == 8'h66 && hdrService inside {8'h32, 8'h33}
    |-> s_status(8'h06)) else $error("empty request not partial");
  a_bad_class: assert property (
    hdrValid && hdrReady && hdrEmpty && hdrClass != 8'h66 |=> rspValid && rspStatus == 8'h05)
    else $error("foreign class not refused");
  // A stalled client must find the same status and byte when it finally takes them.
  a_status_stands: assert property (
    rspValid && !rspReady |=> rspValid && $stable(rspStatus))
    else $error("status dropped before taken");
  a_byte_stands: assert property (
    rspByteValid && !rspByteReady |=> rspByteValid && $stable(rspByte))
    else $error("response byte dropped before taken");
endmodule
bind prg_gateway prg_gateway_monitor prg_gateway_monitor_i (.*);

// file: bench/prg_rec_model.sv
// Record-side responder serving fetch and store accesses of the gateway.
// Shares the bench clock; errSel gives the reply code of the next access.
`timescale 1ns/1ps
module prg_rec_model (
  input wire logic clk, // Clock.
  input wire logic recReqValid, // Access offered.
  output logic recReqReady, // Access taken.
  input wire logic recReqStore, // Store when high.
  input wire logic [7:0] recIndex, // Record index.
  input wire logic [31:0] recLength, // Byte count.
  input wire logic recAbort, // Store cancelled.
  input wire logic recWrValid, // Store byte valid.
  output logic recWrReady, // Store byte taken.
  input wire logic [7:0] recWrData, // Store byte.
  output logic recRspValid, // Reply valid.
  input wire logic recRspReady, // Reply taken.
  output logic [7:0] fieldbusErrorClassCode, // Reply code.
  output logic [31:0] recRspLength, // Reply length.
  output logic recRdValid, // Fetched byte valid.
  input wire logic recRdReady, // Fetched byte taken.
  output logic [7:0] recRdData, // Fetched byte.
  input wire logic [7:0] errSel // Reply code to use.
);
  logic [7:0] got[$];
  initial begin
    int n;
    logic st;
    logic [31:0] len;
    logic [7:0] idx;
    {recReqReady, recWrReady, recRspValid, recRdValid} = 4'h0;
    fieldbusErrorClassCode = 8'h00;
    recRspLength = 32'h0;
    recRdData = 8'h00;
    forever begin
      @(posedge clk);
      if (recReqValid) begin
        recReqReady <= 1'b1;
        @(posedge clk);
        st = recReqStore;
        len = recLength;
        idx = recIndex;
        recReqReady <= 1'b0;
        n = 0;
        // Random stalls on store bytes exercise the gateway's hold behaviour.
        while (st && n < len && !recAbort) begin
          recWrReady <= ($urandom_range(0, 3) != 0);
          @(posedge clk);
          if (recWrValid && recWrReady) begin
            got.push_back(recWrData);
            n++;
          end
        end
        recWrReady <= 1'b0;
        if (!recAbort) begin
          recRspValid <= 1'b1;
          fieldbusErrorClassCode <= errSel;
          recRspLength <= len;
          do @(posedge clk); while (!recRspReady);
          // Released lines show inverted values so stale data never looks valid.
          recRspValid <= 1'b0;
          fieldbusErrorClassCode <= ~errSel;
          recRspLength <= ~len;
          for (int i = 0; i < len && !st && errSel == 8'h00; i++) begin
            recRdValid <= 1'b1;
            recRdData <= idx + i[7:0];
            do @(posedge clk); while (!recRdReady);
          end
          recRdValid <= 1'b0;
          recRdData <= ~recRdData;
        end
      end
    end
  end
endmodule

// file: bench/prg_gateway_tb.sv
// Self-checking bench for the parameter record gateway.
// Bench drives the client side; prg_rec_model serves the record side.
`timescale 1ns/1ps
module prg_gateway_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rspReady = 1'b1;
  logic hdrValid = 0, hdrEmpty = 0, reqValid = 0, reqLast = 0, rspByteReady = 0;
  logic fwActivateStart = 0, fwActivateDone = 0, factoryRestore = 0;
  logic [7:0] hdrService = 0, hdrClass = 0, hdrInstance = 0, reqData = 0, errSel = 0;
  logic hdrReady, reqReady, rspByteValid, rspValid, recReqValid, recReqReady, recReqStore;
  logic recAbort, recWrValid, recWrReady, recRspValid, recRspReady, recRdValid, recRdReady;
  logic cyclicHoldNetA, cyclicHoldNetB, loadDefaults;
  logic [7:0] rspByte, rspStatus, recIndex, recWrData, fieldbusErrorClassCode, recRdData;
  logic [31:0] recLength, recRspLength;
  logic [7:0] recCodes[24] = '{8'h00, 8'ha7, 8'ha9, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5,
    8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'he0, 8'he1, 8'ha0, 8'ha1, 8'ha2,
    8'ha8, 8'h5a};
  logic [7:0] cipCodes[24] = '{8'h00, 8'h1e, 8'h14, 8'h09, 8'h15, 8'h05, 8'h0e, 8'h16, 8'h10,
    8'h0f, 8'h20, 8'h20, 8'h29, 8'h2c, 8'h0e, 8'h0c, 8'h02, 8'h24, 8'h03, 8'h1f, 8'h1f, 8'h1f,
    8'h1f, 8'h1f};
  int err_total = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  prg_gateway prg_gateway_i (.*);
  prg_rec_model prg_rec_model_i (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One request: header, request bytes, then response bytes and status.
  task automatic run(input logic [7:0] svc, cls, inst, input logic emp,
    input logic [7:0] req[$], input logic [7:0] exp[$], input logic [7:0] st);
    logic [7:0] got[$];
    int t;
    hdrValid <= 1'b1;
    hdrService <= svc;
    hdrClass <= cls;
    hdrInstance <= inst;
    hdrEmpty <= emp;
    do @(posedge clk); while (!hdrReady);
    hdrValid <= 1'b0;
    foreach (req[i]) begin
      reqValid <= 1'b1;
      reqData <= req[i];
      reqLast <= (i == req.size() - 1);
      do @(posedge clk); while (!reqReady);
    end
    reqValid <= 1'b0;
    for (t = 0; t < 400; t++) begin
      rspByteReady <= ($urandom_range(0, 1) == 1);
      rspReady <= ($urandom_range(0, 1) == 1);
      @(posedge clk);
      if (rspByteValid && rspByteReady) got.push_back(rspByte);
      if (rspValid && rspReady) break;
    end
    chk(t < 400, 1);
    chk(got.size(), exp.size());
    foreach (exp[i]) if (i < got.size()) chk(got[i], exp[i]);
    chk(rspStatus, st);
  endtask
  initial begin
    #500us;
    chk(32'h0, 32'h1);
    finish_test();
  end
  initial begin
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [7:0] inst;
    logic [31:0] len;
    int t;
    void'($urandom(26));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t = 0;
    repeat (3) begin
      @(posedge clk);
      t += loadDefaults;
    end
    chk(t, 1);
    factoryRestore <= 1'b1;
    @(posedge clk);
    factoryRestore <= 1'b0;
    t = 0;
    repeat (3) begin
      @(posedge clk);
      t += loadDefaults;
    end
    chk(t, 1);
    $display("defaults test done");
    for (int k = 0; k < 6; k++) begin
      len = (k % 3) * 3;
      inst = 8'($urandom);
      q = '{len[31:24], len[23:16], len[15:8], len[7:0]};
      e = q;
      if (k < 3) begin
        for (int i = 0; i < len; i++) e.push_back(inst + i[7:0]);
        run(8'h32, 8'h66, inst, 1'b0, q, e, 8'h00);
      end else begin
        for (int i = 0; i < len; i++) q.push_back(8'($urandom));
        e = {};
        prg_rec_model_i.got.delete();
        run(8'h33, 8'h66, inst, 1'b0, q, e, 8'h00);
        chk(prg_rec_model_i.got.size(), len);
        foreach (prg_rec_model_i.got[i]) chk(prg_rec_model_i.got[i], q[i + 4]);
      end
    end
    $display("fetch and store tests done");
    e = {};
    for (int k = 1; k < 24; k++) begin
      errSel <= recCodes[k];
      q = '{8'h00, 8'h00, 8'h00, 8'h02};
      run(8'h32, 8'h66, 8'($urandom), 1'b0, q, e, cipCodes[k]);
    end
    errSel <= 8'h00;
    $display("translation test done");
    q = {};
    run(8'h32, 8'h66, 8'h00, 1'b1, q, e, 8'h06);
    run(8'h33, 8'h66, 8'hff, 1'b1, q, e, 8'h06);
    run(8'h32, 8'h65, 8'h01, 1'b1, q, e, 8'h05);
    q = '{8'h00, 8'h00};
    run(8'h32, 8'h66, 8'h02, 1'b0, q, e, 8'h06);
    q = '{8'h00, 8'h00, 8'h00, 8'h04, 8'haa, 8'h55};
    run(8'h33, 8'h66, 8'h03, 1'b0, q, e, 8'h06);
    // Payload longer than declared, foreign class and unknown service are drained.
    q = '{8'h00, 8'h00, 8'h00, 8'h01, 8'haa, 8'h55};
    run(8'h33, 8'h66, 8'h05, 1'b0, q, e, 8'h15);
    run(8'h32, 8'h66, 8'h06, 1'b0, q, e, 8'h15);
    run(8'h32, 8'h65, 8'h07, 1'b0, q, e, 8'h05);
    run(8'h4c, 8'h66, 8'h08, 1'b0, q, e, 8'h08);
    $display("short request test done");
    fwActivateStart <= 1'b1;
    @(posedge clk);
    fwActivateStart <= 1'b0;
    repeat ($urandom_range(1, 9)) @(posedge clk);
    chk({cyclicHoldNetA, cyclicHoldNetB}, 2'b11);
    fwActivateStart <= 1'b1;
    fwActivateDone <= 1'b1;
    @(posedge clk);
    fwActivateStart <= 1'b0;
    @(posedge clk);
    chk({cyclicHoldNetA, cyclicHoldNetB}, 2'b11);
    fwActivateDone <= 1'b0;
    @(posedge clk);
    chk({cyclicHoldNetA, cyclicHoldNetB}, 2'b00);
    $display("firmware test done");
    finish_test();
  end
endmodule
